// *** hdl/ccg_cfg.svh ***
// constants for the core clock gate and low-power control block
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH

`define CCG_NUM_CORES    2
`define CCG_ASYNC_BRIDGE 1'b1
`define CCG_GATE_RST     1'b1

// servicing access request bits
`define CCG_SVC_W        6
`define CCG_SVC_UTIL     0
`define CCG_SVC_GIC      1
`define CCG_SVC_DBG      2
`define CCG_SVC_SNOOP    3
`define CCG_SVC_MAINT    4
`define CCG_SVC_PEER     5

// state and mode codes
`define CCG_ST_RUN       3'b001
`define CCG_ST_DRAIN     3'b010
`define CCG_ST_WAIT      3'b100
`define CCG_WK_WFI       2'h0
`define CCG_WK_WFE       2'h1
`define CCG_WK_TIMED_WAIT_INTERRUPT      2'h2
`define CCG_WK_TIMED_WAIT_EVENT      2'h3
`define CCG_PM_ON        2'h0
`define CCG_PM_FULL_RETENTION_MODE  2'h1
`define CCG_PM_OFF       2'h2
`define CCG_PM_WARM      2'h3

`endif

// *** hdl/ccg_pkg.sv ***
// types shared by the core clock gate block
`include "ccg_cfg.svh"
package ccg_pkg;
  typedef enum logic [2:0] {
    CCG_RUN   = `CCG_ST_RUN,
    CCG_DRAIN = `CCG_ST_DRAIN,
    CCG_WAIT  = `CCG_ST_WAIT
  } ccg_core_st_t;

  typedef enum logic [1:0] {
    CCG_WFI  = `CCG_WK_WFI,
    CCG_WFE  = `CCG_WK_WFE,
    CCG_TIMED_WAIT_INTERRUPT = `CCG_WK_TIMED_WAIT_INTERRUPT,
    CCG_TIMED_WAIT_EVENT = `CCG_WK_TIMED_WAIT_EVENT
  } ccg_wait_kind_t;

  typedef enum logic [1:0] {
    CCG_PM_ON       = `CCG_PM_ON,
    CCG_PM_FULL_RETENTION_MODE = `CCG_PM_FULL_RETENTION_MODE,
    CCG_PM_OFF      = `CCG_PM_OFF,
    CCG_PM_WARM     = `CCG_PM_WARM
  } ccg_pm_mode_t;

  typedef struct packed {
    logic                  wait_exec;
    ccg_wait_kind_t        wait_kind;
    logic                  retired;
    logic                  stores_done;
    logic                  event_set;
    logic                  wakeup;
    logic [`CCG_SVC_W-1:0] svc_req;
    logic                  svc_done;
    logic                  prep_done;
  } ccg_core_in_t;

  typedef struct packed {
    logic in_wait;
    logic event_clr;
    logic clk_en;
  } ccg_core_out_t;

  function automatic logic ccg_is_event_wait(input ccg_wait_kind_t k);
    return (k == CCG_WFE) || (k == CCG_TIMED_WAIT_EVENT);
  endfunction
endpackage : ccg_pkg

// *** hdl/ccg_gate_en.sv ***
// enable flop of one architectural clock gate in the bridge
`include "ccg_cfg.svh"
module ccg_gate_en (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic run_i,
  output logic      gate_en_o
);
  import ccg_pkg::*;

  // gate opens out of reset so the complex can start up
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      gate_en_o <= `CCG_GATE_RST;
    end else if (clk_en_i) begin
      gate_en_o <= run_i;
    end
  end
endmodule // ccg_gate_en

// *** hdl/ccg_top.sv ***
// core clock gating, reset scope and low-power wait control
`include "ccg_cfg.svh"
module ccg_top (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   cold_reset_i,
  input  wire logic                   warm_reset_i,
  input  wire logic                   vector_busy_i,
  input  ccg_pkg::ccg_core_in_t       core_i     [`CCG_NUM_CORES],
  input  wire logic [`CCG_NUM_CORES-1:0] pm_req_i,
  input  ccg_pkg::ccg_pm_mode_t       pm_mode_i  [`CCG_NUM_CORES],
  output ccg_pkg::ccg_core_out_t      core_o     [`CCG_NUM_CORES],
  output logic [`CCG_NUM_CORES-1:0]   pm_accept_o,
  output logic                        shared_clk_en_o,
  output logic                        vector_clk_en_o,
  output logic                        clk_src_sel_o,
  output logic                        core_func_rst_o,
  output logic                        core_keep_rst_o
);
  import ccg_pkg::*;

  localparam int N = `CCG_NUM_CORES;

  ccg_core_st_t      state_reg  [N];
  logic [N-1:0]      svc_reg;
  logic [N-1:0]      evclr_reg;
  logic [N-1:0]      accept_reg;
  logic [N-1:0]      core_run;
  logic [N-1:0]      core_gate;
  logic              shared_run;
  logic              vec_reg;
  logic              src_reg;
  logic              func_rst_reg;
  logic              keep_rst_reg;

  // ------------------------------------------------------------
  // clock source and reset scope
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      src_reg <= 1'b0;
    end else if (clk_en_i) begin
      src_reg <= `CCG_ASYNC_BRIDGE;
    end
  end

  // warm reset leaves the retained domains alone
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      func_rst_reg <= 1'b1;
      keep_rst_reg <= 1'b1;
    end else if (clk_en_i) begin
      func_rst_reg <= cold_reset_i | warm_reset_i;
      keep_rst_reg <= cold_reset_i;
    end
  end

  // ------------------------------------------------------------
  // per-core wait state machine
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < N; i++) begin
      if (reset_i || func_rst_reg) begin
        state_reg[i] <= CCG_RUN;
      end else if (clk_en_i) begin
        case (state_reg[i])
          CCG_RUN: begin
            if (core_i[i].wait_exec) begin
              if (ccg_is_event_wait(core_i[i].wait_kind) &&
                  core_i[i].event_set) begin
                state_reg[i] <= CCG_RUN;
              end else begin
                state_reg[i] <= CCG_DRAIN;
              end
            end
          end
          CCG_DRAIN: begin
            // a wakeup during drain turns the wait into a no-op
            if (core_i[i].wakeup) begin
              state_reg[i] <= CCG_RUN;
            end else if (core_i[i].retired &&
                         core_i[i].stores_done) begin
              state_reg[i] <= CCG_WAIT;
            end
          end
          CCG_WAIT: begin // only wakeup leaves
            if (core_i[i].wakeup) begin
              state_reg[i] <= CCG_RUN;
            end
          end
          default: begin
            state_reg[i] <= CCG_RUN;
          end
        endcase
      end
    end
  end

  // event clear pulse when an event wait is skipped
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < N; i++) begin
      if (reset_i || func_rst_reg) begin
        evclr_reg[i] <= 1'b0;
      end else if (clk_en_i) begin
        evclr_reg[i] <= (state_reg[i] == CCG_RUN) &&
                        core_i[i].wait_exec &&
                        ccg_is_event_wait(core_i[i].wait_kind) &&
                        core_i[i].event_set;
      end
    end
  end

  // ------------------------------------------------------------
  // temporary re-enable for servicing accesses
  // ------------------------------------------------------------
  // a new request in the clearing cycle keeps the clock on
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < N; i++) begin
      if (reset_i || func_rst_reg) begin
        svc_reg[i] <= 1'b0;
      end else if (clk_en_i) begin
        if ((state_reg[i] == CCG_WAIT) && (|core_i[i].svc_req)) begin
          svc_reg[i] <= 1'b1;
        end else if (core_i[i].svc_done ||
                     (state_reg[i] != CCG_WAIT)) begin
          svc_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // bridge clock gates, one per core and one shared
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N; i++) begin
      // gated outside the core; re-enable never leaves wait
      core_run[i] = (state_reg[i] != CCG_WAIT) || svc_reg[i];
    end
    shared_run = |core_run;
  end

  for (genvar g = 0; g < N; g++) begin : g_core_gate
    ccg_gate_en u_gate (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .clk_en_i  (clk_en_i),
      .run_i     (core_run[g]),
      .gate_en_o (core_gate[g])
    );
  end

  ccg_gate_en u_shared_gate (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .run_i     (shared_run),
    .gate_en_o (shared_clk_en_o)
  );

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vec_reg <= 1'b1;
    end else if (clk_en_i) begin
      vec_reg <= vector_busy_i;
    end
  end

  // ------------------------------------------------------------
  // power mode requests from the policy controllers
  // ------------------------------------------------------------
  // requests arrive only from the controllers
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < N; i++) begin
      if (reset_i) begin
        accept_reg[i] <= 1'b0;
      end else if (clk_en_i) begin
        accept_reg[i] <= pm_req_i[i] && core_i[i].prep_done &&
                         ((pm_mode_i[i] != CCG_PM_FULL_RETENTION_MODE) ||
                          (state_reg[i] == CCG_WAIT));
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      core_o[i].in_wait   = (state_reg[i] == CCG_WAIT);
      core_o[i].event_clr = evclr_reg[i];
      core_o[i].clk_en    = core_gate[i];
    end
  end

  assign pm_accept_o     = accept_reg;
  assign vector_clk_en_o = vec_reg;
  assign clk_src_sel_o   = src_reg;
  assign core_func_rst_o = func_rst_reg;
  assign core_keep_rst_o = keep_rst_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_drained(i);
    state_reg[i] == CCG_DRAIN && core_i[i].retired &&
    core_i[i].stores_done && !core_i[i].wakeup && clk_en_i;
  endsequence

  sequence s_serviced(i);
    state_reg[i] == CCG_WAIT && svc_reg[i] && core_i[i].svc_done &&
    !(|core_i[i].svc_req) && !core_i[i].wakeup && clk_en_i;
  endsequence

  for (genvar g = 0; g < N; g++) begin : g_chk
    a_drain_to_wait: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      s_drained(g) |=> core_o[g].in_wait
      ) else $error("core did not wait after drain");
    a_store_block: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      (state_reg[g] == CCG_DRAIN && !core_i[g].stores_done)
      |=> !core_o[g].in_wait
      ) else $error("wait entered with pending stores");
    a_event_skip: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      (state_reg[g] == CCG_RUN && core_i[g].wait_exec && clk_en_i &&
       ccg_is_event_wait(core_i[g].wait_kind) && core_i[g].event_set)
      |=> state_reg[g] == CCG_RUN && core_o[g].event_clr
      ) else $error("event wait not skipped");
    a_wake_exit: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      (core_o[g].in_wait && core_i[g].wakeup && clk_en_i)
      |=> !core_o[g].in_wait
      ) else $error("wakeup did not leave wait");
    a_svc_clock_on: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      (core_o[g].in_wait && (|core_i[g].svc_req) && !core_i[g].wakeup &&
       clk_en_i) ##1 clk_en_i |=> core_o[g].clk_en
      ) else $error("service did not enable clock");
    a_svc_stays_wait: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      (core_o[g].in_wait && !core_i[g].wakeup) |=> core_o[g].in_wait
      ) else $error("left wait without wakeup");
    a_svc_regate: assert property (@(posedge clk_sys_i)
      disable iff (reset_i || func_rst_reg)
      s_serviced(g) ##1 (clk_en_i && core_o[g].in_wait &&
        !(|core_i[g].svc_req)) |=> !core_o[g].clk_en
      ) else $error("clock not regated after service");
    a_pm_prep: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      pm_accept_o[g] |-> $past(core_i[g].prep_done)
      ) else $error("mode accepted before preparation");
    a_ret_wait: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      (pm_accept_o[g] && $past(pm_mode_i[g]) == CCG_PM_FULL_RETENTION_MODE)
      |-> $past(state_reg[g]) == CCG_WAIT
      ) else $error("retention accepted while running");
  end

  a_shared_gate: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    !shared_clk_en_o |-> !(|core_gate)
    ) else $error("shared clock gated while a core runs");
  a_vector_idle: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    (!vector_busy_i && clk_en_i) |=> !vector_clk_en_o
    ) else $error("vector clock running while idle");
  a_warm_scope: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    (warm_reset_i && !cold_reset_i && clk_en_i)
    |=> core_func_rst_o && !core_keep_rst_o
    ) else $error("warm reset scope wrong");
  a_cold_scope: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    (cold_reset_i && clk_en_i) |=> core_func_rst_o && core_keep_rst_o
    ) else $error("cold reset scope wrong");
  a_clk_source: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    clk_en_i |=> clk_src_sel_o == `CCG_ASYNC_BRIDGE
    ) else $error("clock source select wrong");
endmodule // ccg_top

// *** verif/ccg_ppc_model.sv ***
// power policy controller model for one core power domain
module ccg_ppc_model (
  input  wire logic           clk_sys_i,
  input  wire logic           reset_i,
  input  wire logic           start_i,
  input  ccg_pkg::ccg_pm_mode_t mode_i,
  input  wire logic           accept_i,
  output logic                pm_req_o,
  output ccg_pkg::ccg_pm_mode_t pm_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccg_pkg::*;

  // one model per core domain
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pm_req_o  <= 1'b0;
      pm_mode_o <= CCG_PM_ON;
    end else if (start_i && !pm_req_o) begin
      pm_req_o  <= 1'b1;
      pm_mode_o <= mode_i;
    end else if (accept_i) begin
      // request is held until accepted, never withdrawn early
      pm_req_o <= 1'b0;
    end
  end
endmodule // ccg_ppc_model

// *** verif/ccg_top_tb.sv ***
// self-checking bench for the core clock gate and low-power block
`include "ccg_cfg.svh"
module ccg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccg_pkg::*;
  localparam int P_WAIT = 0;
  localparam int P_CLK  = 1;
  localparam int P_EVC  = 2;
  localparam int P_ACC  = 3;
  localparam int P_SHR  = 4;

  logic                      clk_sys_i = 1'b0;
  logic                      reset_i = 1'b1;
  logic                      clk_en_i = 1'b1;
  logic                      cold_rst = 1'b0;
  logic                      warm_rst = 1'b0;
  logic                      vec_busy = 1'b0;
  ccg_core_in_t              core_in   [`CCG_NUM_CORES];
  ccg_core_out_t             core_out  [`CCG_NUM_CORES];
  ccg_pm_mode_t              pm_mode   [`CCG_NUM_CORES];
  ccg_pm_mode_t              pm_sel    [`CCG_NUM_CORES];
  logic [`CCG_NUM_CORES-1:0] pm_req;
  logic [`CCG_NUM_CORES-1:0] pm_start = '0;
  logic [`CCG_NUM_CORES-1:0] pm_accept;
  logic                      shared_en;
  logic                      vector_en;
  logic                      src_sel;
  logic                      func_rst;
  logic                      keep_rst;
  int                        miscompares = 0;
  int                        cmp_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  ccg_top i_ccg_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .cold_reset_i(cold_rst), .warm_reset_i(warm_rst),
    .vector_busy_i(vec_busy), .core_i(core_in), .pm_req_i(pm_req),
    .pm_mode_i(pm_mode), .core_o(core_out), .pm_accept_o(pm_accept),
    .shared_clk_en_o(shared_en), .vector_clk_en_o(vector_en),
    .clk_src_sel_o(src_sel), .core_func_rst_o(func_rst),
    .core_keep_rst_o(keep_rst));

  for (genvar g = 0; g < `CCG_NUM_CORES; g++) begin : g_ppc
    ccg_ppc_model i_ccg_ppc_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .start_i(pm_start[g]), .mode_i(pm_sel[g]), .accept_i(pm_accept[g]),
      .pm_req_o(pm_req[g]), .pm_mode_o(pm_mode[g]));
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(string name, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  function automatic logic probe(int w, int c);
    case (w)
      P_WAIT:  return core_out[c].in_wait;
      P_CLK:   return core_out[c].clk_en;
      P_EVC:   return core_out[c].event_clr;
      P_ACC:   return pm_accept[c];
      default: return shared_en;
    endcase
  endfunction

  // bounded poll, so a stuck output ends as a mismatch, not a hang
  task automatic wait_for(string name, int w, int c, logic lvl, int lim);
    int n;
    n = 0;
    while (probe(w, c) !== lvl && n < lim) begin
      tick();
      n++;
    end
    chk(name, lvl, probe(w, c));
  endtask

  task automatic issue(int c, ccg_wait_kind_t k);
    core_in[c].wait_kind = k;
    core_in[c].wait_exec = 1'b1;
    tick();
    core_in[c].wait_exec = 1'b0;
  endtask

  task automatic sleep(int c, ccg_wait_kind_t k);
    issue(c, k);
    wait_for("in_wait", P_WAIT, c, 1'b1, 6);
    tick();
    chk("clk_en", 1'b0, core_out[c].clk_en);
  endtask

  task automatic wake(int c);
    core_in[c].wakeup = 1'b1;
    wait_for("in_wait", P_WAIT, c, 1'b0, 4);
    core_in[c].wakeup = 1'b0;
    tick();
    chk("clk_en", 1'b1, core_out[c].clk_en);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_drain();
    core_in[0].retired = 1'b0;
    issue(0, CCG_WFI);
    tick(4);
    chk("in_wait", 1'b0, core_out[0].in_wait);
    core_in[0].retired = 1'b1;
    core_in[0].stores_done = 1'b0;
    tick(4);
    chk("in_wait", 1'b0, core_out[0].in_wait);
    core_in[0].stores_done = 1'b1;
    wait_for("in_wait", P_WAIT, 0, 1'b1, 4);
    wake(0);
  endtask

  task automatic t_kinds();
    for (int k = 0; k < 4; k++) begin
      sleep(1, ccg_wait_kind_t'(k));
      chk("shared_en", 1'b1, shared_en);
      chk("clk_en0", 1'b1, core_out[0].clk_en);
      wake(1);
    end
  endtask

  task automatic t_event();
    core_in[1].event_set = 1'b1;
    issue(1, CCG_WFE);
    wait_for("event_clr", P_EVC, 1, 1'b1, 2);
    issue(1, CCG_TIMED_WAIT_EVENT);
    chk("in_wait", 1'b0, core_out[1].in_wait);
    wait_for("event_clr", P_EVC, 1, 1'b1, 2);
    tick(2);
    chk("event_clr", 1'b0, core_out[1].event_clr);
    sleep(1, CCG_WFI);
    core_in[1].event_set = 1'b0;
    wake(1);
  endtask

  task automatic t_both();
    sleep(0, CCG_WFE);
    sleep(1, CCG_TIMED_WAIT_INTERRUPT);
    wait_for("shared_en", P_SHR, 0, 1'b0, 3);
    wake(1);
    wait_for("shared_en", P_SHR, 0, 1'b1, 3);
  endtask

  task automatic t_svc();
    for (int b = 0; b < `CCG_SVC_W; b++) begin
      core_in[0].svc_req = 6'h01 << b;
      tick();
      core_in[0].svc_req = 6'h00;
      wait_for("svc clk_en", P_CLK, 0, 1'b1, 4);
      tick(3);
      chk("svc clk_en", 1'b1, core_out[0].clk_en);
      chk("in_wait", 1'b1, core_out[0].in_wait);
      core_in[0].svc_done = 1'b1;
      tick();
      core_in[0].svc_done = 1'b0;
      wait_for("regate", P_CLK, 0, 1'b0, 4);
      chk("in_wait", 1'b1, core_out[0].in_wait);
    end
    // a new request in the done cycle must keep the clock on
    core_in[0].svc_req = 6'h08;
    tick();
    core_in[0].svc_req = 6'h00;
    wait_for("svc clk_en", P_CLK, 0, 1'b1, 4);
    core_in[0].svc_done = 1'b1;
    core_in[0].svc_req = 6'h02;
    tick();
    core_in[0].svc_done = 1'b0;
    core_in[0].svc_req = 6'h00;
    tick(2);
    chk("svc set wins", 1'b1, core_out[0].clk_en);
    core_in[0].svc_done = 1'b1;
    tick();
    core_in[0].svc_done = 1'b0;
    wait_for("regate", P_CLK, 0, 1'b0, 4);
  endtask

  task automatic t_pm();
    pm_sel[0] = CCG_PM_FULL_RETENTION_MODE;
    pm_start[0] = 1'b1;
    tick();
    pm_start[0] = 1'b0;
    tick(5);
    chk("accept", 1'b0, pm_accept[0]);
    sleep(0, CCG_WFI);
    wait_for("accept", P_ACC, 0, 1'b1, 4);
    wait_for("accept", P_ACC, 0, 1'b0, 3);
    wake(0);
    core_in[0].prep_done = 1'b0;
    pm_sel[0] = CCG_PM_OFF;
    pm_start[0] = 1'b1;
    tick();
    pm_start[0] = 1'b0;
    tick(4);
    chk("accept", 1'b0, pm_accept[0]);
    core_in[0].prep_done = 1'b1;
    wait_for("accept", P_ACC, 0, 1'b1, 3);
    tick(3);
    pm_sel[1] = CCG_PM_WARM;
    pm_start[1] = 1'b1;
    tick();
    pm_start[1] = 1'b0;
    wait_for("accept1", P_ACC, 1, 1'b1, 3);
    wait_for("accept1", P_ACC, 1, 1'b0, 3);
  endtask

  task automatic t_vector();
    vec_busy = 1'b0;
    tick();
    chk("vector_en", 1'b0, vector_en);
    vec_busy = 1'b1;
    tick();
    chk("vector_en", 1'b1, vector_en);
    clk_en_i = 1'b0;
    vec_busy = 1'b0;
    tick(2);
    chk("frozen", 1'b1, vector_en);
    clk_en_i = 1'b1;
    tick();
    chk("vector_en", 1'b0, vector_en);
  endtask

  task automatic t_resets();
    sleep(0, CCG_WFI);
    warm_rst = 1'b1;
    tick(2);
    chk("func_rst", 1'b1, func_rst);
    chk("keep_rst", 1'b0, keep_rst);
    chk("in_wait", 1'b0, core_out[0].in_wait);
    warm_rst = 1'b0;
    tick(3);
    chk("func_rst", 1'b0, func_rst);
    cold_rst = 1'b1;
    tick(2);
    chk("func_rst", 1'b1, func_rst);
    chk("keep_rst", 1'b1, keep_rst);
    cold_rst = 1'b0;
    tick(3);
    chk("keep_rst", 1'b0, keep_rst);
    // block reset in mid-run, then a wait right after release
    reset_i = 1'b1;
    tick(2);
    chk("src_sel", 1'b0, src_sel);
    chk("keep_rst", 1'b1, keep_rst);
    reset_i = 1'b0;
    tick(2);
    chk("src_sel", `CCG_ASYNC_BRIDGE, src_sel);
    chk("keep_rst", 1'b0, keep_rst);
    chk("shared_en", 1'b1, shared_en);
    sleep(1, CCG_WFI);
    wake(1);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    for (int c = 0; c < `CCG_NUM_CORES; c++) begin
      core_in[c] = '0;
      core_in[c].retired = 1'b1;
      core_in[c].stores_done = 1'b1;
      core_in[c].prep_done = 1'b1;
      pm_sel[c] = CCG_PM_ON;
    end
    tick(5);
    reset_i = 1'b0;
    tick(2);
    chk("src_sel", `CCG_ASYNC_BRIDGE, src_sel);
    chk("func_rst", 1'b0, func_rst);
    chk("shared_en", 1'b1, shared_en);
    t_drain();
    t_kinds();
    t_event();
    t_both();
    t_svc();
    wake(0);
    t_pm();
    t_vector();
    t_resets();
    end_of_test();
  end

  // whole run is well under a thousand cycles; allow ample margin
  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end
endmodule // ccg_top_tb
